//--- rtl/smcc_pkg.sv
// Overview of operation
// - Six modes: FAST, SLOW, SLEEP, three idles.
// - FAST runs fast clock divided 1 to 64.
// - Select 000-110 divide fast by 2^n; 111 slow.
// - SLOW mode runs system clock from slow oscillator.
// - Halt with keeps 00 enters SLEEP.
// - Halt with keeps 01 enters idle slow only.
// - Halt with keeps 11 enters idle both on.
// - Halt with keeps 10 enters idle fast only.
// - In SLOW fast oscillator follows its enable bit, or runs while a switch to a fast source is pending.
// - Bit 1 keeps fast oscillator during halt.
// - Bit 0 keeps slow oscillator during halt.
// - Unimplemented register bits read as zero.
// - Clock switch completes after four system ticks.
// - Enabling fast oscillator clears, then sets stable.
// - Fast enable bit 0, resets to one.
// - FAST mode keeps every clock running.
// - Switch to SLOW waits for slow oscillator ready.
package smcc_pkg;
  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SEL = 8'h00;
  localparam logic [7:0] OFF_FOSC = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam int CKS_LSB = 5;
  localparam int KEEP_FAST_BIT = 1;
  localparam int KEEP_SLOW_BIT = 0;
  localparam int FOSC_EN_BIT = 0;
  localparam int FOSC_STB_BIT = 1;
  localparam int STAT_SEL_LSB = 8;
  localparam int STAT_PEND_BIT = 12;
  localparam logic [2:0] CKS_RST = 3'h0;
  localparam logic [2:0] CKS_SLOW = 3'h7;
  localparam logic KEEP_RST = 1'b0;
  localparam logic FOSC_EN_RST = 1'b1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam logic [2:0] SW_SYS_TICKS = 3'h4;
  localparam int FAST_STAB_NS = 20_000;
  localparam int FAST_STAB_CYC = (FAST_STAB_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SLOW_DIV = 312;
  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    MD_FAST = 6'h01,
    MD_SLOW = 6'h02,
    MD_SLEEP = 6'h04,
    MD_IDLE_SLOW_ONLY = 6'h08,
    MD_IDLE_BOTH_ON = 6'h10,
    MD_IDLE_FAST_ONLY = 6'h20
  } smcc_mode_t;
endpackage

//--- rtl/smcc_clk_div.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// Enable divider: one tick every limit+1 enabled cycles
// ------------------------------------------------------------------
module smcc_clk_div #(
  parameter int W = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [W-1:0] limit,
  output logic tick
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_tick;

  // Counter freezes while its oscillator is stopped, so no tick leaks out.
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (en) begin
      if (cnt >= limit) begin
        next_cnt = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Registers only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

//--- rtl/smcc_stab_tmr.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// Oscillator start-up timer
// ------------------------------------------------------------------
module smcc_stab_tmr #(
  parameter int CYC = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_on,
  output logic stable
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_stable;

  // A stopped oscillator drops the flag at once and restarts the count.
  always_comb begin
    next_cnt = cnt;
    next_stable = stable;
    if (!osc_on) begin
      next_cnt = '0;
      next_stable = 1'b0;
    end else if (cnt < 16'(CYC)) begin
      next_cnt = cnt + 16'h0001;
    end else begin
      next_stable = 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      stable <= 1'b0;
    end else begin
      cnt <= next_cnt;
      stable <= next_stable;
    end
  end
endmodule
`default_nettype wire

//--- rtl/smcc_top.sv
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module smcc_top #(
  parameter int SLOW_DIV = smcc_pkg::SLOW_DIV,
  parameter int FAST_STAB_CYC = smcc_pkg::FAST_STAB_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_halt,
  input wire logic wake_req,
  input wire logic watchdog_on,
  input wire logic slow_osc_ready_pin,
  output logic fast_osc_on,
  output logic fast_clk_run,
  output logic slow_clk_run,
  output logic slow_osc_run,
  output logic cpu_run,
  output logic sys_clk_en,
  output logic [5:0] mode_out
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0] cks, next_cks;
  logic keep_f, next_keep_f, keep_s, next_keep_s;
  logic fosc_en, next_fosc_en;
  logic [31:0] next_prdata;
  smcc_pkg::smcc_mode_t mode, next_mode;
  logic [2:0] act_sel, next_act, tgt, next_tgt, sw_cnt, next_sw;
  logic pend, next_pend;
  logic next_fosc_on, next_sclk, next_sosc, next_cpu;
  logic slow_rdy_m, slow_rdy;
  logic fast_tick, slow_tick, fosc_stable, src_tick, sys_gate;
  logic act_slow, tgt_ready, wr_any, wr_sel, wr_fosc;
  logic [8:0] fast_limit;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
    !(hit(paddr, smcc_pkg::OFF_SEL) || hit(paddr, smcc_pkg::OFF_FOSC) ||
      hit(paddr, smcc_pkg::OFF_STAT));
  assign wr_any = psel && penable && pwrite;
  assign wr_sel = wr_any && hit(paddr, smcc_pkg::OFF_SEL);
  assign wr_fosc = wr_any && hit(paddr, smcc_pkg::OFF_FOSC);

  // Register writes in the access phase; read data latched in the setup phase.
  always_comb begin
    next_cks = cks;
    next_keep_f = keep_f;
    next_keep_s = keep_s;
    next_fosc_en = fosc_en;
    next_prdata = prdata;
    if (wr_sel) begin
      next_cks = pwdata[smcc_pkg::CKS_LSB +: 3];
      next_keep_f = pwdata[smcc_pkg::KEEP_FAST_BIT];
      next_keep_s = pwdata[smcc_pkg::KEEP_SLOW_BIT];
    end
    if (wr_fosc) begin
      next_fosc_en = pwdata[smcc_pkg::FOSC_EN_BIT];
    end
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (hit(paddr, smcc_pkg::OFF_SEL)) begin
        next_prdata[smcc_pkg::CKS_LSB +: 3] = cks;
        next_prdata[smcc_pkg::KEEP_FAST_BIT] = keep_f;
        next_prdata[smcc_pkg::KEEP_SLOW_BIT] = keep_s;
      end else if (hit(paddr, smcc_pkg::OFF_FOSC)) begin
        next_prdata[smcc_pkg::FOSC_EN_BIT] = fosc_en;
        next_prdata[smcc_pkg::FOSC_STB_BIT] = fosc_stable;
      end else if (hit(paddr, smcc_pkg::OFF_STAT)) begin
        next_prdata[5:0] = mode;
        next_prdata[smcc_pkg::STAT_SEL_LSB +: 3] = act_sel;
        next_prdata[smcc_pkg::STAT_PEND_BIT] = pend;
      end
    end
  end

  // Register file storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cks <= smcc_pkg::CKS_RST;
      keep_f <= smcc_pkg::KEEP_RST;
      keep_s <= smcc_pkg::KEEP_RST;
      fosc_en <= smcc_pkg::FOSC_EN_RST;
      prdata <= 32'h0000_0000;
    end else begin
      cks <= next_cks;
      keep_f <= next_keep_f;
      keep_s <= next_keep_s;
      fosc_en <= next_fosc_en;
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator models and system clock enable
  // ----------------------------------------------------------------
  // The ready pin is asynchronous, so it passes two flops first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_rdy_m <= 1'b0;
      slow_rdy <= 1'b0;
    end else begin
      slow_rdy_m <= slow_osc_ready_pin;
      slow_rdy <= slow_rdy_m;
    end
  end

  assign act_slow = (act_sel == smcc_pkg::CKS_SLOW);
  // Divide by 2^sel; pclk stands in for the fast oscillator.
  assign fast_limit = act_slow ? 9'h000 : 9'((9'h001 << act_sel) - 9'h001);
  assign fast_clk_run = fast_osc_on && fosc_stable;

  smcc_clk_div #(.W(9)) u_fast_div (
    .pclk(pclk),
    .presetn(presetn),
    .en(fast_clk_run),
    .limit(fast_limit),
    .tick(fast_tick)
  );

  smcc_clk_div #(.W(9)) u_slow_div (
    .pclk(pclk),
    .presetn(presetn),
    .en(slow_osc_run && slow_rdy),
    .limit(9'(SLOW_DIV - 1)),
    .tick(slow_tick)
  );

  smcc_stab_tmr #(.CYC(FAST_STAB_CYC)) u_fast_stab (
    .pclk(pclk),
    .presetn(presetn),
    .osc_on(fast_osc_on),
    .stable(fosc_stable)
  );

  // The system clock only ticks while its own source is kept alive.
  always_comb begin
    sys_gate = 1'b0;
    unique case (mode)
      smcc_pkg::MD_FAST, smcc_pkg::MD_SLOW: sys_gate = 1'b1;
      smcc_pkg::MD_IDLE_BOTH_ON: sys_gate = 1'b1;
      smcc_pkg::MD_IDLE_SLOW_ONLY: sys_gate = act_slow;
      smcc_pkg::MD_IDLE_FAST_ONLY: sys_gate = !act_slow;
      smcc_pkg::MD_SLEEP: sys_gate = 1'b0;
    endcase
  end
  assign src_tick = act_slow ? slow_tick : fast_tick;
  assign sys_clk_en = src_tick && sys_gate;

  // ----------------------------------------------------------------
  // Clock source switching
  // ----------------------------------------------------------------
  // A slow target is ready on its next edge, which needs its oscillator
  // ready; a fast target is ready once its oscillator is on and settled.
  assign tgt_ready = (tgt == smcc_pkg::CKS_SLOW) ? slow_tick : fast_clk_run;

  // Four current system ticks, then alignment to the target source.
  always_comb begin
    next_act = act_sel;
    next_tgt = tgt;
    next_pend = pend;
    next_sw = sw_cnt;
    if (wr_sel) begin
      next_tgt = pwdata[smcc_pkg::CKS_LSB +: 3];
      next_pend = (pwdata[smcc_pkg::CKS_LSB +: 3] != act_sel);
      next_sw = 3'h0;
    end else if (pend) begin
      if (sw_cnt < smcc_pkg::SW_SYS_TICKS) begin
        if (sys_clk_en) begin
          next_sw = sw_cnt + 3'h1;
        end
      end else if (tgt_ready) begin
        next_act = tgt;
        next_pend = 1'b0;
      end
    end
  end

  // Switch state registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sel <= smcc_pkg::CKS_RST;
      tgt <= smcc_pkg::CKS_RST;
      pend <= 1'b0;
      sw_cnt <= 3'h0;
    end else begin
      act_sel <= next_act;
      tgt <= next_tgt;
      pend <= next_pend;
      sw_cnt <= next_sw;
    end
  end

  // ----------------------------------------------------------------
  // Operating mode machine
  // ----------------------------------------------------------------
  // Low-power entry needs halt; select writes only move FAST/SLOW.
  always_comb begin
    next_mode = mode;
    unique case (mode)
      smcc_pkg::MD_FAST, smcc_pkg::MD_SLOW: begin
        if (cpu_halt) begin
          unique case ({keep_f, keep_s})
            2'b00: next_mode = smcc_pkg::MD_SLEEP;
            2'b01: next_mode = smcc_pkg::MD_IDLE_SLOW_ONLY;
            2'b11: next_mode = smcc_pkg::MD_IDLE_BOTH_ON;
            2'b10: next_mode = smcc_pkg::MD_IDLE_FAST_ONLY;
          endcase
        end else begin
          next_mode = (next_act == smcc_pkg::CKS_SLOW) ?
            smcc_pkg::MD_SLOW : smcc_pkg::MD_FAST;
        end
      end
      smcc_pkg::MD_SLEEP, smcc_pkg::MD_IDLE_SLOW_ONLY,
      smcc_pkg::MD_IDLE_BOTH_ON, smcc_pkg::MD_IDLE_FAST_ONLY: begin
        if (wake_req) begin
          next_mode = act_slow ? smcc_pkg::MD_SLOW : smcc_pkg::MD_FAST;
        end
      end
    endcase
  end

  // Oscillator and clock gates follow the next mode so they line up
  // with the mode register.
  always_comb begin
    next_fosc_on = 1'b0;
    next_sclk = 1'b0;
    next_sosc = 1'b1;
    next_cpu = 1'b0;
    unique case (next_mode)
      smcc_pkg::MD_FAST: begin
        next_fosc_on = 1'b1;
        next_sclk = 1'b1;
        next_cpu = 1'b1;
      end
      smcc_pkg::MD_SLOW: begin
        // A pending return to a fast source must start the oscillator.
        next_fosc_on = next_fosc_en ||
          (next_pend && next_tgt != smcc_pkg::CKS_SLOW);
        next_sclk = 1'b1;
        next_cpu = 1'b1;
      end
      smcc_pkg::MD_IDLE_SLOW_ONLY: next_sclk = 1'b1;
      smcc_pkg::MD_IDLE_BOTH_ON: begin
        next_fosc_on = 1'b1;
        next_sclk = 1'b1;
      end
      smcc_pkg::MD_IDLE_FAST_ONLY: next_fosc_on = 1'b1;
      smcc_pkg::MD_SLEEP: next_sosc = watchdog_on;
    endcase
  end

  // Mode and gate registers; power-on starts in FAST, undivided.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= smcc_pkg::MD_FAST;
      fast_osc_on <= 1'b1;
      slow_clk_run <= 1'b1;
      slow_osc_run <= 1'b1;
      cpu_run <= 1'b1;
    end else begin
      mode <= next_mode;
      fast_osc_on <= next_fosc_on;
      slow_clk_run <= next_sclk;
      slow_osc_run <= next_sosc;
      cpu_run <= next_cpu;
    end
  end
  assign mode_out = mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_halt_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_run && cpu_halt && !keep_f && !keep_s |=> mode == smcc_pkg::MD_SLEEP && !cpu_run)
    else $error("halt with no keep bits did not sleep");
  a_halt_idle_slow: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_run && cpu_halt && !keep_f && keep_s |=>
    mode == smcc_pkg::MD_IDLE_SLOW_ONLY && !fast_osc_on && slow_clk_run)
    else $error("idle slow only entry wrong");
  a_halt_idle_both: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_run && cpu_halt && keep_f && keep_s |=>
    mode == smcc_pkg::MD_IDLE_BOTH_ON && fast_osc_on && slow_clk_run)
    else $error("idle both on entry wrong");
  a_halt_idle_fast: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_run && cpu_halt && keep_f && !keep_s |=>
    mode == smcc_pkg::MD_IDLE_FAST_ONLY && fast_osc_on && !slow_clk_run)
    else $error("idle fast only entry wrong");
  a_sleep_gates: assert property (@(posedge pclk) disable iff (!presetn)
    mode == smcc_pkg::MD_SLEEP |->
    !sys_clk_en && !slow_clk_run && slow_osc_run == $past(watchdog_on))
    else $error("sleep gating wrong");
  a_idle_sysclk: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == smcc_pkg::MD_IDLE_SLOW_ONLY && !act_slow) ||
    (mode == smcc_pkg::MD_IDLE_FAST_ONLY && act_slow) |-> !sys_clk_en)
    else $error("system clock ran from a stopped source");
  a_fast_all_on: assert property (@(posedge pclk) disable iff (!presetn)
    mode == smcc_pkg::MD_FAST |-> fast_osc_on && slow_clk_run && slow_osc_run && cpu_run)
    else $error("clock stopped in FAST mode");
  a_slow_fosc: assert property (@(posedge pclk) disable iff (!presetn)
    mode == smcc_pkg::MD_SLOW && !pend && !$past(pend) |-> fast_osc_on == fosc_en)
    else $error("fast oscillator ignores enable in SLOW");
  a_switch_wait: assert property (@(posedge pclk) disable iff (!presetn)
    act_sel != $past(act_sel) |-> $past(sw_cnt) == smcc_pkg::SW_SYS_TICKS)
    else $error("clock switched before four system ticks");
  a_stable_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fast_osc_on) |=> !fosc_stable [*2])
    else $error("stable flag not cleared on enable");
  a_no_lp_write: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_run && !cpu_halt |=> cpu_run)
    else $error("low power entered without halt");
  a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && hit(paddr, smcc_pkg::OFF_FOSC) |->
    prdata[31:2] == 30'h0000_0000)
    else $error("unimplemented bits read nonzero");
endmodule
`default_nettype wire

//--- bench/smcc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module smcc_tb_top;
  // ----------------------------------------------------------------
  // Stimulus and design
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, cpu_halt, wake_req, watchdog_on, slow_rdy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, fast_osc_on, fast_clk_run, slow_clk_run, slow_osc_run;
  logic cpu_run, sys_clk_en;
  logic [5:0] mode_out;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;
  // Short counts keep the run brief; some wait and tick windows below, such as STAB + 3, 4 * SDIV and 8 * SDIV + 20, are derived from these.
  localparam int SDIV = 4;
  localparam int STAB = 3;
  smcc_top #(.SLOW_DIV(SDIV), .FAST_STAB_CYC(STAB)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_halt(cpu_halt),
    .wake_req(wake_req), .watchdog_on(watchdog_on), .slow_osc_ready_pin(slow_rdy),
    .fast_osc_on(fast_osc_on), .fast_clk_run(fast_clk_run), .slow_clk_run(slow_clk_run),
    .slow_osc_run(slow_osc_run), .cpu_run(cpu_run), .sys_clk_en(sys_clk_en),
    .mode_out(mode_out));
  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("errors %0d compared %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // A slave that never answers counts as a mismatch.
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1, "no ready from slave");
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One-cycle pulse on wake or halt; a selector avoids passing a signal by reference.
  task automatic pulse(input logic wake);
    @(posedge pclk);
    if (wake) begin
      wake_req <= 1'b1;
    end else begin
      cpu_halt <= 1'b1;
    end
    @(posedge pclk);
    wake_req <= 1'b0;
    cpu_halt <= 1'b0;
    @(negedge pclk);
  endtask
  // Waits on negedges for a mode, counting the cycles spent.
  task automatic wait_mode(input logic [5:0] m, input int max);
    n = 0;
    while (mode_out !== m && n < max) begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic ticks(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(negedge pclk);
      if (sys_clk_en === 1'b1) c++;
    end
  endtask
  // Halt with given keep bits; the select field is written to 111 or 000 per sel_slow.
  task automatic halt_case(input logic [1:0] keep, input logic dog, input logic sel_slow);
    logic [5:0] m, home;
    int c;
    home = sel_slow ? smcc_pkg::MD_SLOW : smcc_pkg::MD_FAST;
    m = keep == 2'b00 ? smcc_pkg::MD_SLEEP : keep == 2'b01 ? smcc_pkg::MD_IDLE_SLOW_ONLY :
        keep == 2'b11 ? smcc_pkg::MD_IDLE_BOTH_ON : smcc_pkg::MD_IDLE_FAST_ONLY;
    apb(1'b1, 8'h00, {24'h0, sel_slow ? 3'h7 : 3'h0, 3'h0, keep});
    watchdog_on <= dog;
    @(negedge pclk);
    chk(32'(mode_out), 32'(home), "write alone kept run mode");
    pulse(1'b0);
    chk(32'(mode_out), 32'(m), "halt mode");
    chk(32'(cpu_run), 32'h0, "cpu stopped");
    chk(32'(slow_clk_run), 32'(keep[0]), "slow clock in halt");
    chk(32'(slow_osc_run), 32'(keep != 2'b00 || dog), "slow osc in halt");
    chk(32'(fast_osc_on), 32'(keep[1]), "fast osc in halt");
    ticks(4 * SDIV, c);
    chk(32'(c != 0), 32'(sel_slow ? keep[0] : keep[1]), "system clock in idle");
    pulse(1'b1);
    chk(32'(mode_out), 32'(home), "wake");
    n = 0;
    while (fast_clk_run !== 1'b1 && n < 20 && !sel_slow) begin
      @(negedge pclk);
      n++;
    end
    // A fast oscillator that never settles again must not pass silently.
    if (!sel_slow) begin
      chk(32'(fast_clk_run), 32'h1, "fast clock back after wake");
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_halt = 1'b0;
    wake_req = 1'b0;
    watchdog_on = 1'b0;
    slow_rdy = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(32'(mode_out), 32'(smcc_pkg::MD_FAST), "reset mode");
    chk({28'h0, fast_osc_on, slow_clk_run, slow_osc_run, cpu_run}, 32'hF, "fast clocks");
    chk(32'(fast_clk_run), 32'h0, "stable low after reset");
    chk(32'(pready), 32'h1, "slave ready at rest");
    repeat (STAB + 3) @(negedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h3, "fast osc reg reset");
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0, "select reg reset");
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b1, 8'h00, 32'hFFFF_FF1F);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3, "select unused bits read zero");
    apb(1'b1, 8'h04, 32'hFFFF_FFFC);
    apb(1'b0, 8'h04, 32'h0);
    // FAST forces the oscillator on, so only the stable flag stays set.
    chk(rd, 32'h2, "fast reg unused bits zero");
    apb(1'b1, 8'h04, 32'h1);
    repeat (STAB + 3) @(negedge pclk);
    // Every halt variant from FAST with an undivided fast clock.
    halt_case(2'b00, 1'b0, 1'b0);
    halt_case(2'b00, 1'b1, 1'b0);
    halt_case(2'b01, 1'b0, 1'b0);
    halt_case(2'b11, 1'b0, 1'b0);
    halt_case(2'b10, 1'b0, 1'b0);
    // Slow oscillator not ready yet, so the switch must hold off.
    apb(1'b1, 8'h00, 32'hE0);
    wait_mode(smcc_pkg::MD_SLOW, 30);
    chk(32'(mode_out), 32'(smcc_pkg::MD_FAST), "switch waits for slow osc");
    apb(1'b0, 8'h08, 32'h0);
    chk({31'h0, rd[12]}, 32'h1, "switch pending");
    slow_rdy <= 1'b1;
    apb(1'b1, 8'h00, 32'hE0);
    wait_mode(smcc_pkg::MD_SLOW, 40);
    chk(32'((n >= 4) && (n <= 4 + SDIV + 8)), 32'h1, "switch time");
    chk(32'(cpu_run), 32'h1, "slow run cpu");
    apb(1'b1, 8'h04, 32'h0);
    @(negedge pclk);
    chk(32'(fast_osc_on), 32'h0, "fast off in slow");
    apb(1'b1, 8'h04, 32'h1);
    @(negedge pclk);
    chk({30'h0, fast_osc_on, fast_clk_run}, 32'h2, "stable cleared on enable");
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 20);
    chk(rd, 32'h3, "stable set");
    halt_case(2'b01, 1'b0, 1'b1);
    halt_case(2'b10, 1'b0, 1'b1);
    // Return to FAST after the fast oscillator was stopped.
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h20);
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 30);
    wait_mode(smcc_pkg::MD_FAST, 8 * SDIV + 20);
    chk(32'(mode_out), 32'(smcc_pkg::MD_FAST), "back to fast");
    apb(1'b0, 8'h08, 32'h0);
    chk({29'h0, rd[10:8]}, 32'h1, "active select");
    ticks(16, n);
    chk(32'(n), 32'd8, "divide by two");
    report_and_stop();
  end
  // Cuts a hang short well beyond the expected few hundred cycles.
  initial begin
    #(100 * 20000);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
